//--- core/fsr_status.sv
`timescale 1ns/1ps

// Functional notes
// - Status read answered any time, even busy
// - Opcode 05h, then one bit per clock
// - Two bytes, then restart at byte one bit 7
// - Every repeat carries live field values
// - Chip select release ends read, output floats
// - Bit 7 is lock flag, 1 locked
// - Lock blocks sector protect and global commands
// - Lock cleared on power-up and reset
// - Pin asserted allows lock only 0 to 1
// - Write status changes bit 7 and clears bit 1
// - Bit 6 sequential mode flag, default 0
// - Bit 5 set on erase or program failure
// - Aborted operation never sets error flag
// - Error flag refreshed after every operation
// - Bit 4 reads 1 when pin deasserted
// - Bits 3:2 protection summary, default 11
// - Bit 1 write enable latch, default 0
// - Bit 0 busy flag, 1 while running
// - Latch 0 rejects program, erase, protect, write
// - Byte two: bit 4 reset enable, bit 0 busy
module fsr_status
   import fsr_pkg::*;
(
   input  wire logic mclk,
   input  wire logic nrst,
   input  wire logic cs_n,
   input  wire logic sck,
   input  wire logic si,
   input  wire logic wp_n,
   input  wire logic seq_mode_in,
   input  wire logic busy_in,
   input  wire logic op_end,
   input  wire logic op_fail,
   input  wire logic op_abort,
   input  wire logic wel_clear,
   input  wire logic any_protected,
   input  wire logic all_protected,
   output logic      so,
   output logic      so_oe_n,
   output logic      protection_lock_flag,
   output logic      write_enable_latch,
   output logic      reset_command_enable,
   output logic      prot_cmd_ok,
   output logic      write_cmd_ok
);
   import fsr_pkg::*;

   // --------------------------------------------------------------------------
   // Pin synchronisers and edge finders
   // --------------------------------------------------------------------------
   logic [FSR_PIN_W-1:0] pins_sync;
   logic                 cs_n_s;
   logic                 sck_s;
   logic                 si_s;
   logic                 wp_n_s;
   logic                 sck_rise;
   logic                 sck_fall;
   logic                 cs_rise;
   logic                 cs_fall;

   // Each level of the link clock must last at least three system clocks, or an
   // edge is lost in the synchronisers.
   fsr_sync #(
      .W (FSR_PIN_W)
   ) u_sync (
      .mclk      (mclk),
      .nrst      (nrst),
      .pin_in    ({wp_n, si, sck, cs_n}),
      .pin_reset (FSR_PIN_IDLE),
      .pin_sync  (pins_sync)
   );

   assign cs_n_s = pins_sync[0];
   assign sck_s  = pins_sync[1];
   assign si_s   = pins_sync[2];
   assign wp_n_s = pins_sync[3];

   fsr_edge u_sck_edge (
      .mclk  (mclk),
      .nrst  (nrst),
      .level (sck_s),
      .rise  (sck_rise),
      .fall  (sck_fall)
   );

   fsr_edge u_cs_edge (
      .mclk  (mclk),
      .nrst  (nrst),
      .level (cs_n_s),
      .rise  (cs_rise),
      .fall  (cs_fall)
   );

   // --------------------------------------------------------------------------
   // State
   // --------------------------------------------------------------------------
   fsr_state_t state_reg;
   fsr_state_t state_next;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic [2:0] bit_reg;
   logic [7:0] op_reg;
   logic [7:0] data_reg;
   logic       data_ok_reg;
   logic       op_ok_reg;
   logic [3:0] idx_reg;
   logic       so_reg;
   logic       so_oe_n_reg;
   logic       lock_reg;
   logic       wel_reg;
   logic       reset_command_enable_reg;
   logic       err_reg;
   logic [1:0] sum_reg;
   logic       prot_ok_reg;
   logic       wr_ok_reg;

   // --------------------------------------------------------------------------
   // Serial decode
   // --------------------------------------------------------------------------
   logic                  active;
   logic                  bit_in;
   logic                  byte_done;
   logic [FSR_WORD_W-1:0] word;
   logic [1:0]            sum_live;
   logic                  end_frame;
   logic                  is_wr_en;
   logic                  is_wr_dis;
   logic                  is_wr_st;
   logic                  is_wr_st2;
   logic                  wp_asserted;
   logic                  lock_wr;
   logic                  lock_new;
   logic                  reset_command_enable_wr;
   logic                  wel_set;
   logic                  wel_drop;
   logic                  lock_next;
   logic                  wel_next;

   // Commands act only when chip select rises after a whole opcode, so a frame
   // cut inside the opcode leaves every field and the latch untouched.
   // Command effects are applied from the synchronised rising edge of chip select.
   assign active     = ~cs_n_s;
   assign bit_in     = active & sck_rise;
   assign byte_done  = bit_in & (bit_reg == FSR_BIT_LAST);
   assign shift_next = {shift_reg[6:0], si_s};
   assign end_frame  = cs_rise & op_ok_reg;

   // Summary is computed from live sector state.
   assign sum_live = all_protected ? FSR_SUM_ALL :
                     any_protected ? FSR_SUM_SOME : FSR_SUM_NONE;

   // Live word: every bit is chosen at the moment it is shifted out.
   // Byte two reads zero apart from the reset enable and a copy of busy.
   always_comb begin
      word               = '0;
      word[FSR_B1_LOCK]  = lock_reg;
      word[FSR_B1_SEQ]   = seq_mode_in;
      word[FSR_B1_ERR]   = err_reg;
      word[FSR_B1_WPP]   = wp_n_s;
      word[FSR_B1_SUMHI] = sum_reg[1];
      word[FSR_B1_SUMLO] = sum_reg[0];
      word[FSR_B1_WEL]   = wel_reg;
      word[FSR_B1_BUSY]  = busy_in;
      word[FSR_B2_RESET_COMMAND_ENABLE]  = reset_command_enable_reg;
      word[FSR_B2_BUSY]  = busy_in;
   end

   // --------------------------------------------------------------------------
   // Frame-end command effects
   // --------------------------------------------------------------------------
   assign is_wr_en    = end_frame & (op_reg == FSR_OP_WR_ENABLE);
   assign is_wr_dis   = end_frame & (op_reg == FSR_OP_WR_DISABLE);
   assign is_wr_st    = end_frame & (op_reg == FSR_OP_WR_STATUS);
   assign is_wr_st2   = end_frame & (op_reg == FSR_OP_WR_STATUS2);
   assign wp_asserted = ~wp_n_s;

   // Only the lock bit of the data byte is used by write status; write status 2 uses only bit 4, the reset enable.
   // With the protect pin asserted the data can only raise the lock, never drop it.
   assign lock_new = wp_asserted ? (lock_reg | data_reg[FSR_DATA_LOCK])
                                 : data_reg[FSR_DATA_LOCK];
   assign lock_wr  = is_wr_st & wel_reg & data_ok_reg;
   assign reset_command_enable_wr  = is_wr_st2 & wel_reg & data_ok_reg;
   assign lock_next = lock_wr ? lock_new : lock_reg;

   // A completed status write clears the latch whether or not it applied.
   // Write enable wins over a clear from the device logic in the same cycle.
   assign wel_set  = is_wr_en;
   assign wel_drop = is_wr_dis | is_wr_st | is_wr_st2 | wel_clear;
   assign wel_next = wel_set ? 1'b1 : (wel_drop ? 1'b0 : wel_reg);

   // --------------------------------------------------------------------------
   // Command sequencer
   // --------------------------------------------------------------------------
   // A frame that is neither a status read nor a status write falls into the
   // tail state and is ignored until chip select rises.
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         FSR_ST_IDLE: begin
            if (active) begin
               state_next = FSR_ST_OPCODE;
            end
         end
         FSR_ST_OPCODE: begin
            if (byte_done) begin
               if (shift_next == FSR_OP_RD_STATUS) begin
                  state_next = FSR_ST_STATUS;
               end else if (shift_next == FSR_OP_WR_STATUS ||
                            shift_next == FSR_OP_WR_STATUS2) begin
                  state_next = FSR_ST_WDATA;
               end else begin
                  state_next = FSR_ST_TAIL;
               end
            end
         end
         FSR_ST_STATUS: begin
            state_next = FSR_ST_STATUS;
         end
         FSR_ST_WDATA: begin
            if (byte_done) begin
               state_next = FSR_ST_TAIL;
            end
         end
         FSR_ST_TAIL: begin
            state_next = FSR_ST_TAIL;
         end
         default: begin
            state_next = FSR_ST_IDLE;
         end
      endcase
      if (!active) begin
         state_next = FSR_ST_IDLE;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         state_reg   <= FSR_ST_IDLE;
         shift_reg   <= '0;
         bit_reg     <= '0;
         op_reg      <= '0;
         data_reg    <= '0;
         data_ok_reg <= 1'b0;
         op_ok_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (cs_fall) begin
            bit_reg     <= '0;
            op_ok_reg   <= 1'b0;
            data_ok_reg <= 1'b0;
         end else if (bit_in) begin
            shift_reg <= shift_next;
            bit_reg   <= bit_reg + 3'h1;
         end
         if (byte_done && state_reg == FSR_ST_OPCODE) begin
            op_reg    <= shift_next;
            op_ok_reg <= 1'b1;
         end
         if (byte_done && state_reg == FSR_ST_WDATA) begin
            data_reg    <= shift_next;
            data_ok_reg <= 1'b1;
         end
      end
   end

   // --------------------------------------------------------------------------
   // Serial output
   // --------------------------------------------------------------------------
   // Index counts down through the 16-bit word and wraps from 0 to 15.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         idx_reg     <= FSR_IDX_FIRST;
         so_reg      <= 1'b0;
         so_oe_n_reg <= 1'b1;
      end else if (!active) begin
         idx_reg     <= FSR_IDX_FIRST;
         so_oe_n_reg <= 1'b1;
      end else if (state_reg == FSR_ST_STATUS && sck_fall) begin
         so_reg      <= word[idx_reg];
         so_oe_n_reg <= 1'b0;
         idx_reg     <= idx_reg - 4'h1;
      end
   end

   // --------------------------------------------------------------------------
   // Status fields
   // --------------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         lock_reg <= FSR_LOCK_RESET;
         wel_reg  <= FSR_WEL_RESET;
         reset_command_enable_reg <= FSR_RESET_COMMAND_ENABLE_RESET;
         err_reg  <= FSR_ERR_RESET;
         sum_reg  <= FSR_SUM_RESET;
      end else begin
         lock_reg <= lock_next;
         wel_reg  <= wel_next;
         sum_reg  <= sum_live;
         if (reset_command_enable_wr) begin
            reset_command_enable_reg <= data_reg[FSR_DATA_RESET_COMMAND_ENABLE];
         end
         // A finish and an abort in one cycle count as a finish, so a real failure
         // is never lost.
         if (op_end) begin
            err_reg <= op_fail;
         end else if (op_abort) begin
            err_reg <= 1'b0;
         end
      end
   end

   // --------------------------------------------------------------------------
   // Permission outputs for the command logic beside this block
   // --------------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         prot_ok_reg <= 1'b0;
         wr_ok_reg   <= 1'b0;
      end else begin
         // Both permissions follow the next values so that they never lag the
         // latch and the lock by a cycle.
         prot_ok_reg <= ~lock_next & wel_next;
         wr_ok_reg   <= wel_next;
      end
   end

   assign so                   = so_reg;
   assign so_oe_n              = so_oe_n_reg;
   assign protection_lock_flag = lock_reg;
   assign write_enable_latch   = wel_reg;
   assign reset_command_enable = reset_command_enable_reg;
   assign prot_cmd_ok          = prot_ok_reg;
   assign write_cmd_ok         = wr_ok_reg;

endmodule

//--- core/fsr_pkg.sv
package fsr_pkg;

   // -------------------------------------------------------------------------
   // Command codes
   // -------------------------------------------------------------------------
   localparam logic [7:0] FSR_OP_RD_STATUS  = 8'h05;
   localparam logic [7:0] FSR_OP_WR_STATUS  = 8'h01;
   localparam logic [7:0] FSR_OP_WR_STATUS2 = 8'h31;
   localparam logic [7:0] FSR_OP_WR_ENABLE  = 8'h06;
   localparam logic [7:0] FSR_OP_WR_DISABLE = 8'h04;

   // -------------------------------------------------------------------------
   // Status word layout, byte one in the upper half
   // -------------------------------------------------------------------------
   localparam int FSR_WORD_W   = 16;
   localparam int FSR_B1_LOCK  = 15;
   localparam int FSR_B1_SEQ   = 14;
   localparam int FSR_B1_ERR   = 13;
   localparam int FSR_B1_WPP   = 12;
   localparam int FSR_B1_SUMHI = 11;
   localparam int FSR_B1_SUMLO = 10;
   localparam int FSR_B1_WEL   = 9;
   localparam int FSR_B1_BUSY  = 8;
   localparam int FSR_B2_RESET_COMMAND_ENABLE  = 4;
   localparam int FSR_B2_BUSY  = 0;
   localparam int FSR_DATA_LOCK = 7;
   localparam int FSR_DATA_RESET_COMMAND_ENABLE = 4;

   // -------------------------------------------------------------------------
   // Counts and reset values
   // -------------------------------------------------------------------------
   localparam logic [3:0] FSR_IDX_FIRST  = 4'hf;
   localparam logic [2:0] FSR_BIT_LAST   = 3'h7;
   localparam logic [1:0] FSR_SUM_NONE   = 2'h0;
   localparam logic [1:0] FSR_SUM_SOME   = 2'h1;
   localparam logic [1:0] FSR_SUM_ALL    = 2'h3;
   localparam logic [1:0] FSR_SUM_RESET  = 2'h3;
   localparam logic       FSR_LOCK_RESET = 1'h0;
   localparam logic       FSR_WEL_RESET  = 1'h0;
   localparam logic       FSR_RESET_COMMAND_ENABLE_RESET = 1'h0;
   localparam logic       FSR_ERR_RESET  = 1'h0;
   localparam int         FSR_PIN_W      = 4;
   // Idle levels of the synchronised pins, packed as {wp_n, si, sck, cs_n}.
   localparam logic [3:0] FSR_PIN_IDLE   = 4'h9;

   typedef enum logic [2:0] {
      FSR_ST_IDLE   = 3'b000,
      FSR_ST_OPCODE = 3'b001,
      FSR_ST_STATUS = 3'b010,
      FSR_ST_WDATA  = 3'b011,
      FSR_ST_TAIL   = 3'b100
   } fsr_state_t;

endpackage

//--- core/fsr_sync.sv
`timescale 1ns/1ps

// -----------------------------------------------------------------------------
// Two-stage synchroniser for a group of pins
// -----------------------------------------------------------------------------
module fsr_sync #(
   parameter int W = 4
) (
   input  wire logic         mclk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] pin_in,
   input  wire logic [W-1:0] pin_reset,
   output logic      [W-1:0] pin_sync
);

   logic [W-1:0] meta_reg;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge mclk) begin
            if (!nrst) begin
               meta_reg[i] <= pin_reset[i];
               pin_sync[i] <= pin_reset[i];
            end else begin
               meta_reg[i] <= pin_in[i];
               pin_sync[i] <= meta_reg[i];
            end
         end
      end
   endgenerate

endmodule

//--- core/fsr_edge.sv
`timescale 1ns/1ps

// -----------------------------------------------------------------------------
// Edge finder on a synchronised level
// -----------------------------------------------------------------------------
module fsr_edge (
   input  wire logic mclk,
   input  wire logic nrst,
   input  wire logic level,
   output logic      rise,
   output logic      fall
);

   logic last_reg;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         // Following the level in reset keeps a pin that idles low from faking an edge.
         last_reg <= level;
      end else begin
         last_reg <= level;
      end
   end

   assign rise = level & ~last_reg;
   assign fall = ~level & last_reg;

endmodule

//--- verif/fsr_status_props.sv
`timescale 1ns/1ps

// --------------------
// Status block checker
// --------------------
module fsr_status_props (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic wp_n,
   input wire logic seq_mode_in,
   input wire logic busy_in,
   input wire logic op_end,
   input wire logic op_fail,
   input wire logic op_abort,
   input wire logic wel_clear,
   input wire logic any_protected,
   input wire logic all_protected,
   input wire logic so,
   input wire logic so_oe_n,
   input wire logic protection_lock_flag,
   input wire logic write_enable_latch,
   input wire logic reset_command_enable,
   input wire logic prot_cmd_ok,
   input wire logic write_cmd_ok
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   a_reset_values: assert property (
      $rose(nrst) |-> !protection_lock_flag && !write_enable_latch)
      else $error("lock or latch not cleared by reset");
   a_reset_command_enable_default: assert property ($rose(nrst) |-> !reset_command_enable && so_oe_n)
      else $error("reset enable or output not at default");
   a_oe_release: assert property (cs_n [*6] |-> so_oe_n)
      else $error("serial output still driven after deselect");
   a_oe_needs_cs: assert property ($fell(so_oe_n) |-> !cs_n && !$past(cs_n, 100))
      else $error("output driven before a full opcode");
   a_so_on_fall: assert property (!so_oe_n && $changed(so) |-> !sck)
      else $error("serial output moved while clock high");
   a_lock_blocks: assert property (protection_lock_flag |=> !prot_cmd_ok)
      else $error("protect commands allowed while locked");
   a_wel_gates_ok: assert property (
      !write_enable_latch |-> !write_cmd_ok && !prot_cmd_ok)
      else $error("commands allowed without write enable");
   a_lock_fall_wp: assert property ($fell(protection_lock_flag) |-> $past(wp_n, 4))
      else $error("lock cleared while protect pin asserted");
   a_lock_needs_wel: assert property (
      $changed(protection_lock_flag) |-> $past(write_enable_latch))
      else $error("lock changed without write enable");
   a_wel_after_lock: assert property (
      $changed(protection_lock_flag) |-> ##[0:2] !write_enable_latch)
      else $error("write enable kept after status write");

   c_read: cover property ($fell(so_oe_n));
   c_lock_set: cover property ($rose(protection_lock_flag));
   c_lock_clr: cover property ($fell(protection_lock_flag));
   c_prot_ok: cover property ($rose(prot_cmd_ok));
endmodule

bind fsr_status fsr_status_props u_fsr_status_props (
   .mclk(mclk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
   .seq_mode_in(seq_mode_in), .busy_in(busy_in), .op_end(op_end), .op_fail(op_fail),
   .op_abort(op_abort), .wel_clear(wel_clear), .any_protected(any_protected),
   .all_protected(all_protected), .so(so), .so_oe_n(so_oe_n),
   .protection_lock_flag(protection_lock_flag), .write_enable_latch(write_enable_latch),
   .reset_command_enable(reset_command_enable), .prot_cmd_ok(prot_cmd_ok),
   .write_cmd_ok(write_cmd_ok)
);

//--- verif/fsr_host_model.sv
`timescale 1ns/1ps

// -------------------------------------------------
// Host controller, mode 0, clock idles low off frame
// -------------------------------------------------
module fsr_host_model (
   input  wire logic mclk,
   input  wire logic so,
   input  wire logic so_oe_n,
   output logic      cs_n,
   output logic      sck,
   output logic      si
);
   import fsr_pkg::*;

   initial begin
      {cs_n, sck, si} = 3'b100;
   end

   // A released output reads as unknown so it can never match.
   task automatic shift(input logic b, output logic r);
      si <= b;
      repeat (8) @(posedge mclk);
      sck <= 1'b1;
      r = (so_oe_n === 1'b0) ? so : 1'bx;
      repeat (8) @(posedge mclk);
      sck <= 1'b0;
   endtask

   task automatic send(input logic [7:0] op, input logic [7:0] dat, input logic with_dat);
      logic r;
      @(posedge mclk);
      cs_n <= 1'b0;
      for (int i = 7; i >= 0; i--) shift(op[i], r);
      if (with_dat) for (int i = 7; i >= 0; i--) shift(dat[i], r);
      repeat (8) @(posedge mclk);
      cs_n <= 1'b1;
      si <= ~si;
      repeat (8) @(posedge mclk);
   endtask

   task automatic read_status(input int nbits, output logic [47:0] rx);
      logic r;
      rx = '0;
      @(posedge mclk);
      cs_n <= 1'b0;
      for (int i = 7; i >= 0; i--) shift(FSR_OP_RD_STATUS[i], r);
      for (int i = 0; i < nbits; i++) begin
         shift(~si, r);
         rx = {rx[46:0], r};
      end
      repeat (8) @(posedge mclk);
      cs_n <= 1'b1;
      si <= ~si;
      repeat (8) @(posedge mclk);
   endtask
endmodule

//--- verif/tb_fsr_status.sv
`timescale 1ns/1ps

module tb_fsr_status;
   import fsr_pkg::*;

   logic        mclk, nrst, cs_n, sck, si, wp_n, seq_mode_in, busy_in;
   logic        op_end, op_fail, op_abort, wel_clear, any_protected, all_protected;
   logic        so, so_oe_n, protection_lock_flag, write_enable_latch;
   logic        reset_command_enable, prot_cmd_ok, write_cmd_ok;
   logic [47:0] rx;
   logic [20:0] rows [5];
   int          n_mismatch, checks_done;

   fsr_status u_fsr_status (
      .mclk(mclk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
      .seq_mode_in(seq_mode_in), .busy_in(busy_in), .op_end(op_end), .op_fail(op_fail),
      .op_abort(op_abort), .wel_clear(wel_clear), .any_protected(any_protected),
      .all_protected(all_protected), .so(so), .so_oe_n(so_oe_n),
      .protection_lock_flag(protection_lock_flag), .write_enable_latch(write_enable_latch),
      .reset_command_enable(reset_command_enable), .prot_cmd_ok(prot_cmd_ok),
      .write_cmd_ok(write_cmd_ok)
   );

   fsr_host_model u_fsr_host_model (
      .mclk(mclk), .so(so), .so_oe_n(so_oe_n), .cs_n(cs_n), .sck(sck), .si(si)
   );

   task automatic final_report();
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic status(input logic [15:0] exp);
      u_fsr_host_model.read_status(16, rx);
      cmp(rx, {32'h0, exp});
   endtask

   task automatic set_lock(input logic [7:0] dat);
      u_fsr_host_model.send(FSR_OP_WR_ENABLE, 8'h00, 1'b0);
      u_fsr_host_model.send(FSR_OP_WR_STATUS, dat, 1'b1);
   endtask

   task automatic pulse(input logic fail, input logic abort);
      @(posedge mclk);
      {op_end, op_fail, op_abort} <= {~abort, fail, abort};
      @(posedge mclk);
      {op_end, op_abort} <= 2'b00;
      repeat (2) @(posedge mclk);
   endtask

   task automatic do_reset();
      @(posedge mclk);
      nrst <= 1'b0;
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
   endtask

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   initial begin
      #400000;
      n_mismatch++;
      final_report();
   end

   // ------------------------------------------------------------
   // Rows: pin and flag inputs, then the status word they give
   // ------------------------------------------------------------
   initial begin
      rows = '{{5'b10011, 16'h1c00}, {5'b01110, 16'h4501}, {5'b10111, 16'h1d01},
               {5'b00011, 16'h0c00}, {5'b10000, 16'h1000}};
      {nrst, wp_n, seq_mode_in, busy_in, any_protected, all_protected} = 6'b010011;
      {op_end, op_fail, op_abort, wel_clear} = 4'h0;
      n_mismatch = 0;
      checks_done = 0;
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      for (int i = 0; i < 5; i++) begin
         @(posedge mclk);
         {wp_n, seq_mode_in, busy_in, any_protected, all_protected} <= rows[i][20:16];
         status(rows[i][15:0]);
      end
      u_fsr_host_model.send(FSR_OP_WR_ENABLE, 8'h00, 1'b0);
      status(16'h1200);
      cmp({47'h0, prot_cmd_ok}, 48'h1);
      cmp({47'h0, write_cmd_ok}, 48'h1);
      u_fsr_host_model.send(FSR_OP_WR_STATUS, 8'hfd, 1'b1);
      status(16'h9000);
      cmp({47'h0, prot_cmd_ok}, 48'h0);
      cmp({47'h0, write_cmd_ok}, 48'h0);
      @(posedge mclk);
      wp_n <= 1'b0;
      set_lock(8'h00);
      status(16'h8000);
      @(posedge mclk);
      wp_n <= 1'b1;
      set_lock(8'h00);
      status(16'h1000);
      u_fsr_host_model.send(FSR_OP_WR_STATUS, 8'h80, 1'b1);
      status(16'h1000);
      u_fsr_host_model.send(FSR_OP_WR_ENABLE, 8'h00, 1'b0);
      u_fsr_host_model.send(FSR_OP_WR_STATUS, 8'h00, 1'b0);
      status(16'h1000);
      pulse(1'b1, 1'b1);
      status(16'h1000);
      pulse(1'b1, 1'b0);
      status(16'h3000);
      pulse(1'b0, 1'b0);
      status(16'h1000);
      u_fsr_host_model.send(FSR_OP_WR_ENABLE, 8'h00, 1'b0);
      @(posedge mclk);
      wel_clear <= 1'b1;
      @(posedge mclk);
      wel_clear <= 1'b0;
      repeat (2) @(posedge mclk);
      cmp({47'h0, write_enable_latch}, 48'h0);
      // The busy change lands early in the second repeat of the word, before its busy bits.
      fork
         u_fsr_host_model.read_status(35, rx);
         begin
            repeat (400) @(posedge mclk);
            busy_in <= 1'b1;
         end
      join
      cmp(rx, {13'h0, 16'h1000, 16'h1101, 3'b000});
      @(posedge mclk);
      busy_in <= 1'b0;
      u_fsr_host_model.read_status(3, rx);
      cmp(rx, 48'h0);
      cmp({47'h0, so_oe_n}, 48'h1);
      u_fsr_host_model.send(FSR_OP_WR_ENABLE, 8'h00, 1'b0);
      u_fsr_host_model.send(FSR_OP_WR_STATUS2, 8'h10, 1'b1);
      status(16'h1010);
      u_fsr_host_model.send(FSR_OP_WR_ENABLE, 8'h00, 1'b0);
      u_fsr_host_model.send(FSR_OP_WR_DISABLE, 8'h00, 1'b0);
      status(16'h1010);
      cmp({47'h0, write_cmd_ok}, 48'h0);
      set_lock(8'h80);
      do_reset();
      cmp({47'h0, protection_lock_flag}, 48'h0);
      status(16'h1000);
      final_report();
   end
endmodule
